// File: hw/asmp_uart.sv
// Asynchronous serial port with idle-line and address-bit formats.
// Assumes control pins synchronous to mclk; baud_div is at least 3.
`timescale 1ns/1ps
module asmp_uart (
  input  logic        mclk,
  input  logic        rst,
  input  logic        soft_reset_set,
  input  logic        soft_reset_clr,
  input  logic        int_en_wr,
  input  logic        rx_int_enable_wdata,
  input  logic        tx_int_enable_wdata,
  input  logic        char_7bit,
  input  logic        parity_en,
  input  logic        parity_even,
  input  logic        two_stop,
  input  logic        multiproc_format_select,
  input  logic        rx_wake_filter,
  input  logic        error_char_accept,
  input  logic        receiver_enable,
  input  logic        transmitter_enable,
  input  logic [15:0] baud_div,
  input  logic        tx_wr,
  input  logic [7:0]  tx_wdata,
  input  logic        tx_mark_set,
  input  logic        rx_rd,
  input  logic        err_clr,
  input  logic        serial_in_line,
  output logic        soft_reset_bit,
  output logic        rx_int_enable,
  output logic        tx_int_enable,
  output logic        rx_int_flag,
  output logic        tx_ready_flag,
  output logic        tx_empty_flag,
  output logic        rx_address_tag,
  output logic        tx_address_mark,
  output logic        framing_error_flag,
  output logic        parity_error_flag,
  output logic        overrun_error_flag,
  output logic        break_detected_flag,
  output logic        summary_error_flag,
  output logic [7:0]  receive_buffer,
  output logic        serial_out_line
);
  // Majority of three samples
  function automatic logic asmp_maj(input logic a, input logic b,
                                    input logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction

  // Bits between start and stop
  function automatic logic [3:0] asmp_len(input logic seven,
                                          input logic pen,
                                          input logic mm);
    logic [3:0] n;
    n = seven ? asmp_pkg::DATA_BITS_7 : asmp_pkg::DATA_BITS_8;
    return n + {3'h0, mm} + {3'h0, pen};
  endfunction

  // Expected parity bit over data and address bit
  function automatic logic asmp_par(input logic [7:0] d, input logic seven,
                                    input logic mm, input logic ab,
                                    input logic pev);
    logic p;
    p = (^d[6:0]) ^ (d[7] & ~seven) ^ (ab & mm);
    return p ^ ~pev;
  endfunction

  // Character frame, bit 0 first on the line
  function automatic logic [12:0] asmp_frame(input logic [7:0] d,
                                             input logic seven,
                                             input logic pen,
                                             input logic pev,
                                             input logic mm,
                                             input logic ab);
    logic [12:0] f;
    int p;
    f = 13'h1FFF;
    f[0] = 1'b0;
    p = 1;
    for (int i = 0; i < 8; i++)
    begin
      if (i < 7 || !seven)
      begin
        f[p] = d[i];
        p++;
      end
    end
    if (mm)
    begin
      f[p] = ab;
      p++;
    end
    if (pen)
    begin
      f[p] = asmp_par(d, seven, mm, ab, pev);
    end
    return f;
  endfunction

  asmp_pkg::asmp_rx_t rx_st_r;
  logic [15:0] rx_cnt_r;
  logic [3:0]  rx_idx_r;
  logic [10:0] rx_sh_r;
  logic        samp0_r;
  logic        samp1_r;
  logic [15:0] idle_cnt_r;
  logic [3:0]  mark_cnt_r;
  logic        idle_seen_r;
  logic [3:0]  low_cnt_r;
  logic [7:0]  transmit_buffer;
  logic        wake_temp_latch;
  logic        tx_busy_r;
  logic [15:0] tx_cnt_r;
  logic [3:0]  tx_left_r;
  logic [12:0] tx_sh_r;
  logic [15:0] half;
  logic        bit_end;
  logic        at_vote;
  logic        vote;
  logic [3:0]  rx_len;
  logic [3:0]  nd;
  logic [7:0]  rx_data;
  logic        addr_bit;
  logic        par_bit;
  logic        stop_vote;
  logic        fe_now;
  logic        pe_now;
  logic        is_addr;
  logic        accept;
  logic        store;
  logic        ov_now;
  logic        brk_hit;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic        fifo_out_ready;
  logic [asmp_pkg::FIFO_W-1:0] fifo_out_data;
  logic        tx_load;
  logic        tx_bit_end;
  logic        err_wipe;

  assign half     = baud_div >> 1;
  assign bit_end  = rx_cnt_r == baud_div - 16'h1;
  assign at_vote  = rx_cnt_r == half + 16'h1;
  assign vote     = asmp_maj(samp0_r, samp1_r, serial_in_line);
  assign rx_len   = asmp_len(char_7bit, parity_en, multiproc_format_select);
  assign nd       = char_7bit ? asmp_pkg::DATA_BITS_7 : asmp_pkg::DATA_BITS_8;
  assign rx_data  = {rx_sh_r[7] & ~char_7bit, rx_sh_r[6:0]};
  assign addr_bit = rx_sh_r[nd];
  assign par_bit  = rx_sh_r[nd + {3'h0, multiproc_format_select}];
  assign stop_vote = rx_st_r == asmp_pkg::ASMP_RX_BITS && at_vote &&
                     rx_idx_r == rx_len;
  assign fe_now   = !vote;
  assign pe_now   = parity_en && par_bit != asmp_par(rx_data, char_7bit,
                    multiproc_format_select, addr_bit, parity_even);
  assign is_addr  = multiproc_format_select == asmp_pkg::MM_ADDR_BIT ?
                    addr_bit : idle_seen_r;
  assign accept   = stop_vote && (!rx_wake_filter || is_addr);
  assign store    = accept &&
                    (error_char_accept || !(fe_now || pe_now));
  assign ov_now   = store && !fifo_in_ready;
  assign brk_hit  = rx_st_r == asmp_pkg::ASMP_RX_BRK && at_vote && !vote &&
                    low_cnt_r == asmp_pkg::BREAK_LOW_BITS - 4'h1;
  assign fifo_out_ready = !rx_int_flag || rx_rd;
  assign err_wipe = err_clr || rx_rd;

  // Soft reset bit
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      soft_reset_bit <= asmp_pkg::SOFT_RESET_INIT;
    end
    else if (soft_reset_set)
    begin
      soft_reset_bit <= 1'b1;
    end
    else if (soft_reset_clr)
    begin
      soft_reset_bit <= 1'b0;
    end
  end

  // Interrupt enables
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rx_int_enable <= 1'b0;
      tx_int_enable <= 1'b0;
    end
    else if (soft_reset_bit)
    begin
      rx_int_enable <= 1'b0;
      tx_int_enable <= 1'b0;
    end
    else if (int_en_wr)
    begin
      rx_int_enable <= rx_int_enable_wdata;
      tx_int_enable <= tx_int_enable_wdata;
    end
  end

  // Receive state machine
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rx_st_r  <= asmp_pkg::ASMP_RX_IDLE;
      rx_cnt_r <= 16'h0;
      rx_idx_r <= 4'h0;
      rx_sh_r  <= 11'h0;
      samp0_r  <= 1'b1;
      samp1_r  <= 1'b1;
      low_cnt_r <= 4'h0;
    end
    else if (soft_reset_bit)
    begin
      rx_st_r  <= asmp_pkg::ASMP_RX_IDLE;
      rx_cnt_r <= 16'h0;
      rx_idx_r <= 4'h0;
    end
    else
    begin
      rx_cnt_r <= bit_end ? 16'h0 : rx_cnt_r + 16'h1;
      if (rx_cnt_r == half - 16'h1)
      begin
        samp0_r <= serial_in_line;
      end
      if (rx_cnt_r == half)
      begin
        samp1_r <= serial_in_line;
      end
      case (rx_st_r)
        asmp_pkg::ASMP_RX_IDLE:
        begin
          rx_cnt_r <= 16'h1;
          if (receiver_enable && !serial_in_line)
          begin
            rx_st_r <= asmp_pkg::ASMP_RX_START;
          end
        end
        asmp_pkg::ASMP_RX_START:
        begin
          if (serial_in_line && rx_cnt_r < asmp_pkg::DEGLITCH_CYC)
          begin
            rx_st_r <= asmp_pkg::ASMP_RX_IDLE;
          end
          else if (at_vote && vote)
          begin
            rx_st_r <= asmp_pkg::ASMP_RX_IDLE;
          end
          else if (bit_end)
          begin
            rx_st_r  <= asmp_pkg::ASMP_RX_BITS;
            rx_idx_r <= 4'h0;
          end
        end
        asmp_pkg::ASMP_RX_BITS:
        begin
          if (at_vote)
          begin
            rx_sh_r[rx_idx_r] <= vote;
          end
          if (stop_vote)
          begin
            low_cnt_r <= 4'h0;
            rx_st_r <= vote ? asmp_pkg::ASMP_RX_TAIL
                            : asmp_pkg::ASMP_RX_BRK;
          end
          else if (bit_end)
          begin
            rx_idx_r <= rx_idx_r + 4'h1;
          end
        end
        asmp_pkg::ASMP_RX_TAIL:
        begin
          if (bit_end)
          begin
            rx_st_r <= asmp_pkg::ASMP_RX_IDLE;
          end
        end
        asmp_pkg::ASMP_RX_BRK:
        begin
          if (at_vote && vote)
          begin
            rx_st_r <= asmp_pkg::ASMP_RX_IDLE;
          end
          else if (at_vote && low_cnt_r != asmp_pkg::BREAK_LOW_BITS)
          begin
            low_cnt_r <= low_cnt_r + 4'h1;
          end
        end
        default:
        begin
          rx_st_r <= asmp_pkg::ASMP_RX_IDLE;
        end
      endcase
    end
  end

  // Idle line detection
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      idle_cnt_r  <= 16'h0;
      mark_cnt_r  <= 4'h0;
      idle_seen_r <= 1'b0;
    end
    else if (soft_reset_bit || rx_st_r != asmp_pkg::ASMP_RX_IDLE ||
             !serial_in_line)
    begin
      idle_cnt_r <= 16'h0;
      mark_cnt_r <= 4'h0;
      if (soft_reset_bit || stop_vote)
      begin
        idle_seen_r <= 1'b0;
      end
    end
    else if (idle_cnt_r == baud_div - 16'h1)
    begin
      idle_cnt_r <= 16'h0;
      if (mark_cnt_r == asmp_pkg::IDLE_MARK_BITS - 4'h1)
      begin
        idle_seen_r <= 1'b1;
      end
      if (mark_cnt_r != asmp_pkg::IDLE_MARK_BITS)
      begin
        mark_cnt_r <= mark_cnt_r + 4'h1;
      end
    end
    else
    begin
      idle_cnt_r <= idle_cnt_r + 16'h1;
    end
  end

  asmp_fifo #(
    .W (asmp_pkg::FIFO_W),
    .D (asmp_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .flush     (soft_reset_bit),
    .in_valid  (store),
    .in_ready  (fifo_in_ready),
    .in_data   ({is_addr, rx_data}),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // Receive buffer and its flag
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rx_int_flag    <= 1'b0;
      rx_address_tag <= 1'b0;
      receive_buffer <= 8'h0;
    end
    else if (soft_reset_bit)
    begin
      rx_int_flag    <= 1'b0;
      rx_address_tag <= 1'b0;
    end
    else if (fifo_out_ready)
    begin
      rx_int_flag <= fifo_out_valid;
      if (fifo_out_valid)
      begin
        receive_buffer <= fifo_out_data[7:0];
        rx_address_tag <= fifo_out_data[asmp_pkg::TAG_POS];
      end
    end
  end

  // Error flags, set wins over clear
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      framing_error_flag  <= 1'b0;
      parity_error_flag   <= 1'b0;
      overrun_error_flag  <= 1'b0;
      break_detected_flag <= 1'b0;
      summary_error_flag  <= 1'b0;
    end
    else if (soft_reset_bit)
    begin
      framing_error_flag  <= 1'b0;
      parity_error_flag   <= 1'b0;
      overrun_error_flag  <= 1'b0;
      break_detected_flag <= 1'b0;
      summary_error_flag  <= 1'b0;
    end
    else
    begin
      framing_error_flag  <= (accept && fe_now) ||
                             (framing_error_flag && !err_wipe);
      parity_error_flag   <= (accept && pe_now) ||
                             (parity_error_flag && !err_wipe);
      overrun_error_flag  <= ov_now || (overrun_error_flag && !err_wipe);
      break_detected_flag <= brk_hit || (break_detected_flag && !err_wipe);
      summary_error_flag  <= (accept && (fe_now || pe_now)) || ov_now ||
                             brk_hit || (summary_error_flag && !err_wipe);
    end
  end

  assign tx_load = transmitter_enable && !tx_ready_flag && !tx_busy_r &&
                   !soft_reset_bit;
  assign tx_bit_end = tx_cnt_r == baud_div - 16'h1;

  // Transmit buffer and address mark
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      tx_ready_flag   <= asmp_pkg::TX_READY_INIT;
      transmit_buffer <= 8'h0;
      tx_address_mark <= 1'b0;
    end
    else if (soft_reset_bit)
    begin
      tx_ready_flag   <= 1'b1;
      tx_address_mark <= 1'b0;
    end
    else
    begin
      if (tx_load)
      begin
        tx_ready_flag <= 1'b1;
      end
      else if (tx_wr && tx_ready_flag)
      begin
        transmit_buffer <= tx_wdata;
        tx_ready_flag   <= 1'b0;
      end
      if (tx_mark_set)
      begin
        tx_address_mark <= 1'b1;
      end
      else if (tx_load)
      begin
        tx_address_mark <= 1'b0;
      end
    end
  end

  // Transmit shifter and line
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      tx_busy_r       <= 1'b0;
      tx_cnt_r        <= 16'h0;
      tx_left_r       <= 4'h0;
      tx_sh_r         <= 13'h1FFF;
      wake_temp_latch <= 1'b0;
      serial_out_line <= asmp_pkg::LINE_MARK;
      tx_empty_flag   <= 1'b1;
    end
    else if (soft_reset_bit)
    begin
      tx_busy_r       <= 1'b0;
      tx_cnt_r        <= 16'h0;
      wake_temp_latch <= 1'b0;
      serial_out_line <= asmp_pkg::LINE_MARK;
      tx_empty_flag   <= 1'b1;
    end
    else
    begin
      tx_empty_flag <= tx_ready_flag && !tx_busy_r && !tx_load;
      if (tx_load)
      begin
        tx_busy_r       <= 1'b1;
        tx_cnt_r        <= 16'h0;
        wake_temp_latch <= tx_address_mark;
        tx_sh_r <= asmp_frame(transmit_buffer, char_7bit, parity_en,
                              parity_even, multiproc_format_select,
                              tx_address_mark);
        if (tx_address_mark &&
            multiproc_format_select == asmp_pkg::MM_IDLE_LINE)
        begin
          tx_left_r       <= asmp_pkg::TX_IDLE_BITS;
          serial_out_line <= asmp_pkg::LINE_MARK;
        end
        else
        begin
          tx_left_r <= asmp_len(char_7bit, parity_en,
                                multiproc_format_select) +
                       4'h2 + {3'h0, two_stop};
          serial_out_line <= 1'b0;
        end
      end
      else if (tx_busy_r)
      begin
        tx_cnt_r <= tx_bit_end ? 16'h0 : tx_cnt_r + 16'h1;
        if (tx_bit_end)
        begin
          tx_sh_r   <= {1'b1, tx_sh_r[12:1]};
          tx_left_r <= tx_left_r - 4'h1;
          if (tx_left_r == 4'h1)
          begin
            tx_busy_r       <= 1'b0;
            serial_out_line <= asmp_pkg::LINE_MARK;
          end
          else if (wake_temp_latch &&
                   multiproc_format_select == asmp_pkg::MM_IDLE_LINE)
          begin
            serial_out_line <= asmp_pkg::LINE_MARK;
          end
          else
          begin
            serial_out_line <= tx_sh_r[1];
          end
        end
      end
    end
  end
endmodule

// File: hw/asmp_pkg.sv
// Constants, state codes and timing counts for the serial port.
// Assumes a single 100 MHz clock that also serves as the baud source.
package asmp_pkg;
  localparam int MCLK_NS = 10;
  localparam int DEGLITCH_NS = 300;
  localparam logic [15:0] DEGLITCH_CYC =
    16'((DEGLITCH_NS + MCLK_NS - 1) / MCLK_NS);
  localparam logic [3:0] IDLE_MARK_BITS = 4'hA;
  localparam logic [3:0] BREAK_LOW_BITS = 4'hA;
  localparam logic [3:0] TX_IDLE_BITS = 4'hB;
  localparam logic [3:0] DATA_BITS_7 = 4'h7;
  localparam logic [3:0] DATA_BITS_8 = 4'h8;
  localparam int FIFO_W = 9;
  localparam int FIFO_DEPTH = 32;
  localparam int TAG_POS = 8;
  localparam logic MM_IDLE_LINE = 1'b0;
  localparam logic MM_ADDR_BIT = 1'b1;
  localparam logic SOFT_RESET_INIT = 1'b1;
  localparam logic TX_READY_INIT = 1'b1;
  localparam logic LINE_MARK = 1'b1;
  typedef enum logic [2:0] {
    ASMP_RX_IDLE  = 3'h0,
    ASMP_RX_START = 3'h1,
    ASMP_RX_BITS  = 3'h3,
    ASMP_RX_TAIL  = 3'h2,
    ASMP_RX_BRK   = 3'h6
  } asmp_rx_t;
endpackage

// File: hw/asmp_fifo.sv
// Receive character FIFO with valid and ready on both sides.
// Assumes one clock; flush empties it in one cycle.
`timescale 1ns/1ps
module asmp_fifo #(
  parameter int W = 9,
  parameter int D = 32
) (
  input  logic         mclk,
  input  logic         rst,
  input  logic         flush,
  input  logic         in_valid,
  output logic         in_ready,
  input  logic [W-1:0] in_data,
  output logic         out_valid,
  input  logic         out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wr_ptr_r;
  logic [AW:0]  rd_ptr_r;
  logic         push;
  logic         pop;

  assign in_ready  = (wr_ptr_r - rd_ptr_r) != (AW + 1)'(D);
  assign out_valid = wr_ptr_r != rd_ptr_r;
  assign out_data  = mem[rd_ptr_r[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage
  always_ff @(posedge mclk)
  begin
    if (push)
    begin
      mem[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end
    else if (flush)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= wr_ptr_r + (AW + 1)'(1);
      end
      if (pop)
      begin
        rd_ptr_r <= rd_ptr_r + (AW + 1)'(1);
      end
    end
  end
endmodule

// File: sim/asmp_uart_monitor.sv
// Concurrent checks on the serial port, bound to its top module.
// Assumes the bench runs 80 mclk cycles per bit.
`timescale 1ns/1ps
module asmp_uart_monitor (
  input wire logic mclk,
  input wire logic rst,
  input wire logic soft_reset_clr,
  input wire logic tx_mark_set,
  input wire logic rx_rd,
  input wire logic err_clr,
  input wire logic multiproc_format_select,
  input wire logic soft_reset_bit,
  input wire logic rx_int_enable,
  input wire logic rx_int_flag,
  input wire logic tx_ready_flag,
  input wire logic tx_empty_flag,
  input wire logic tx_address_mark,
  input wire logic framing_error_flag,
  input wire logic parity_error_flag,
  input wire logic overrun_error_flag,
  input wire logic break_detected_flag,
  input wire logic summary_error_flag,
  input wire logic serial_out_line
);
  localparam int BIT_LAST = 79;
  wire any_err = framing_error_flag | parity_error_flag |
    overrun_error_flag | break_detected_flag;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence tx_load;
    $rose(tx_ready_flag) && !$past(soft_reset_bit) && !$past(tx_mark_set);
  endsequence
  chk_reset_sets: assert property ($past(rst) |-> soft_reset_bit)
    else $error("soft reset not set");
  chk_reset_holds: assert property
    (soft_reset_bit && !soft_reset_clr |=> soft_reset_bit)
    else $error("soft reset left without clear");
  chk_reset_state: assert property
    ($past(soft_reset_bit) && soft_reset_bit |-> tx_ready_flag &&
     tx_empty_flag && serial_out_line && !rx_int_flag && !rx_int_enable &&
     !tx_address_mark && !summary_error_flag)
    else $error("soft reset state wrong");
  chk_err_summary: assert property
    ($rose(any_err) |-> ##[0:1] summary_error_flag)
    else $error("summary flag missing");
  chk_err_sticky: assert property
    (summary_error_flag && !rx_rd && !err_clr && !soft_reset_bit
     |=> summary_error_flag)
    else $error("error flag dropped");
  chk_err_clear: assert property
    ((rx_rd || err_clr) && !soft_reset_bit |=> !summary_error_flag)
    else $error("error flag not cleared");
  chk_mark_clear: assert property (tx_load |-> !tx_address_mark)
    else $error("address mark kept after load");
  chk_first_bit: assert property
    (tx_load |-> serial_out_line ==
     (!multiproc_format_select && $past(tx_address_mark)))
    else $error("wrong first bit after load");
  chk_bit_time: assert property
    ($fell(serial_out_line) |-> ##BIT_LAST !serial_out_line)
    else $error("low bit too short");
  chk_idle_high: assert property (tx_empty_flag |-> serial_out_line)
    else $error("line low while empty");
endmodule
bind asmp_uart asmp_uart_monitor asmp_uart_monitor_inst (.*);

// File: sim/asmp_node.sv
// Far serial node: drives the receive line, listens on the send line.
// Assumes N mclk cycles per bit, timed from the shared mclk.
`timescale 1ns/1ps
module asmp_node #(
  parameter int N = 80
) (
  input  wire logic mclk,
  output logic      line_out,
  input  wire logic line_in
);
  initial line_out = 1'b1;
  task automatic send(input logic [23:0] b, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(negedge mclk) line_out = b[i];
      repeat (N - 1) @(negedge mclk);
    end
    @(negedge mclk) line_out = 1'b1;
    repeat (N) @(negedge mclk);
  endtask
  task automatic low(input int c);
    @(negedge mclk) line_out = 1'b0;
    repeat (c) @(negedge mclk);
    line_out = 1'b1;
  endtask
  task automatic recv(output logic [23:0] b, input int n);
    int t;
    b = 'x;
    t = 0;
    while (line_in === 1'b1 && t < 2000)
    begin
      @(negedge mclk);
      t++;
    end
    if (t < 2000)
    begin
      repeat (N / 2) @(negedge mclk);
      for (int i = 0; i < n; i++)
      begin
        b[i] = line_in;
        repeat (N) @(negedge mclk);
      end
    end
  endtask
endmodule

// File: sim/asmp_uart_bench.sv
// Self-checking bench for the serial port and its receive FIFO.
// Assumes 100 MHz mclk and 80 mclk cycles per bit.
`timescale 1ns/1ps
`define CHK(nm, ex, ac) \
  begin \
    cmp_count++; \
    if ((ac) !== (ex)) \
    begin \
      fails++; \
      $display("CHECK FAILED %s exp %0h got %0h", nm, ex, ac); \
    end \
  end
module asmp_uart_bench;
  logic mclk, rst, soft_reset_set, soft_reset_clr, int_en_wr, tx_wr;
  logic rx_int_enable_wdata, tx_int_enable_wdata, char_7bit, parity_en;
  logic parity_even, two_stop, multiproc_format_select, rx_wake_filter;
  logic error_char_accept, receiver_enable, transmitter_enable, rx_rd;
  logic tx_mark_set, err_clr, serial_in_line, soft_reset_bit;
  logic rx_int_enable, tx_int_enable, rx_int_flag, tx_ready_flag;
  logic tx_empty_flag, rx_address_tag, tx_address_mark, framing_error_flag;
  logic parity_error_flag, overrun_error_flag, break_detected_flag;
  logic summary_error_flag, serial_out_line;
  logic [15:0] baud_div;
  logic [7:0]  tx_wdata, receive_buffer;
  logic [23:0] got;
  int          fails, cmp_count;
  asmp_uart asmp_uart_inst (.*);
  asmp_node #(.N(80)) asmp_node_inst (.mclk(mclk),
    .line_out(serial_in_line), .line_in(serial_out_line));
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic pulse(ref logic s);
    @(negedge mclk) s = 1'b1;
    @(negedge mclk) s = 1'b0;
  endtask
  task automatic wait_rx;
    int t;
    t = 0;
    while (rx_int_flag !== 1'b1 && t < 2000)
    begin
      @(negedge mclk);
      t++;
    end
    if (t == 2000)
    begin
      fails++;
      close_out;
    end
  endtask
  task automatic rx_expect(input logic [7:0] d, input logic tag);
    wait_rx;
    `CHK("rxd", d, receive_buffer)
    `CHK("tag", tag, rx_address_tag)
    pulse(rx_rd);
  endtask
  task automatic t_reset;
    `CHK("sr", 1'b1, soft_reset_bit)
    `CHK("rdy", 3'h7, {tx_ready_flag, tx_empty_flag, serial_out_line})
    {rx_int_enable_wdata, tx_int_enable_wdata} = 2'b11;
    pulse(int_en_wr);
    `CHK("ie0", 1'b0, rx_int_enable)
    {receiver_enable, transmitter_enable} = 2'b11;
    pulse(soft_reset_clr);
    `CHK("sr0", 1'b0, soft_reset_bit)
    pulse(int_en_wr);
    `CHK("ie1", 2'b11, {rx_int_enable, tx_int_enable})
  endtask
  task automatic t_tx;
    {parity_en, parity_even} = 2'b11;
    tx_wdata = 8'hA7;
    fork
      asmp_node_inst.recv(got, 11);
      pulse(tx_wr);
    join
    `CHK("txp", {2'b11, 8'hA7, 1'b0}, got[10:0])
    {parity_en, multiproc_format_select} = 2'b01;
    pulse(tx_mark_set);
    `CHK("mk1", 1'b1, tx_address_mark)
    tx_wdata = 8'h3C;
    fork
      asmp_node_inst.recv(got, 11);
      pulse(tx_wr);
    join
    `CHK("txa", {2'b11, 8'h3C, 1'b0}, got[10:0])
    `CHK("mk0", 1'b0, tx_address_mark)
    multiproc_format_select = 1'b0;
  endtask
  task automatic t_tx_idle;
    int hi;
    hi = 0;
    pulse(tx_mark_set);
    tx_wdata = 8'h00;
    pulse(tx_wr);
    fork
      asmp_node_inst.recv(got, 10);
      while (serial_out_line === 1'b1 && hi < 2000)
      begin
        @(negedge mclk);
        hi++;
      end
      begin
        @(negedge mclk);
        `CHK("rdy", 1'b1, tx_ready_flag)
        tx_wdata = 8'h5A;
        pulse(tx_wr);
      end
    join
    `CHK("idle", 1'b1, hi >= 880 && hi <= 884)
    `CHK("txw", {2'b01, 8'h5A, 1'b0}, got[9:0])
  endtask
  task automatic t_rx_format;
    asmp_node_inst.send(24'({1'b1, 8'h6B, 1'b0}), 10);
    rx_expect(8'h6B, 1'b1);
    {multiproc_format_select, parity_en, parity_even} = 3'h7;
    asmp_node_inst.send(24'({3'b101, 8'h01, 1'b0}), 12);
    rx_expect(8'h01, 1'b1);
    `CHK("pe", 1'b0, parity_error_flag)
    {char_7bit, parity_even} = 2'b10;
    asmp_node_inst.send(24'({2'b11, 1'b0, 7'h55, 1'b0}), 11);
    rx_expect(8'h55, 1'b0);
    {char_7bit, parity_en} = 2'b00;
  endtask
  task automatic t_filter;
    rx_wake_filter = 1'b1;
    asmp_node_inst.send(24'({2'b10, 8'h11, 1'b0}), 11);
    asmp_node_inst.send(24'({2'b11, 8'h22, 1'b0}), 11);
    rx_expect(8'h22, 1'b1);
    rx_wake_filter = 1'b0;
    asmp_node_inst.low(20);
    repeat (200) @(negedge mclk);
    asmp_node_inst.low(35);
    repeat (200) @(negedge mclk);
    `CHK("glitch", 2'b00, {rx_int_flag, summary_error_flag})
  endtask
  task automatic t_rx_off;
    fork
      asmp_node_inst.send(24'({2'b11, 8'h44, 1'b0}), 11);
      begin
        repeat (300) @(negedge mclk);
        receiver_enable = 1'b0;
      end
    join
    rx_expect(8'h44, 1'b1);
    asmp_node_inst.send(24'({2'b11, 8'h45, 1'b0}), 11);
    repeat (10) @(negedge mclk);
    `CHK("rxoff", 1'b0, rx_int_flag)
    receiver_enable = 1'b1;
  endtask
  task automatic t_rx_err;
    {multiproc_format_select, parity_en, parity_even} = 3'h3;
    asmp_node_inst.send(24'({2'b10, 8'h01, 1'b0}), 11);
    repeat (10) @(negedge mclk);
    `CHK("pe1", 3'h6, {parity_error_flag, summary_error_flag, rx_int_flag})
    pulse(err_clr);
    `CHK("pe0", 2'b00, {parity_error_flag, summary_error_flag})
    error_char_accept = 1'b1;
    asmp_node_inst.send(24'({2'b01, 8'h02, 1'b0}), 11);
    wait_rx;
    `CHK("fe", 9'h102, {framing_error_flag, receive_buffer})
    `CHK("tg0", 1'b0, rx_address_tag)
    pulse(rx_rd);
    `CHK("fe0", 2'b00, {framing_error_flag, rx_int_flag})
    {error_char_accept, parity_en} = 2'b00;
    asmp_node_inst.send(24'h000000, 20);
    repeat (5) @(negedge mclk);
    `CHK("brk", 3'h6, {break_detected_flag, summary_error_flag, rx_int_flag})
    pulse(soft_reset_set);
    @(negedge mclk);
    `CHK("srst", 3'h1, {break_detected_flag, rx_int_enable, tx_ready_flag})
    pulse(soft_reset_clr);
  endtask
  task automatic t_overrun;
    int n;
    multiproc_format_select = 1'b1;
    for (int i = 0; i < 34; i++)
      asmp_node_inst.send(24'({2'b10, 8'(i), 1'b0}), 11);
    `CHK("ovr", 2'b11, {overrun_error_flag, summary_error_flag})
    n = 0;
    while (rx_int_flag === 1'b1 && n < 40)
    begin
      if (n < 32)
        `CHK("fifo", 8'(n), receive_buffer)
      pulse(rx_rd);
      repeat (3) @(negedge mclk);
      n++;
    end
    `CHK("drain", 1'b1, n >= 32)
    `CHK("ovr0", 1'b0, overrun_error_flag)
  endtask
  task automatic close_out;
    $display("fails=%0d compares=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    {soft_reset_set, soft_reset_clr, int_en_wr, rx_int_enable_wdata,
     tx_int_enable_wdata, char_7bit, parity_en, parity_even, two_stop,
     multiproc_format_select, rx_wake_filter, error_char_accept, rx_rd,
     receiver_enable, transmitter_enable, tx_wr, tx_mark_set, err_clr} = '0;
    fails = 0;
    cmp_count = 0;
    tx_wdata = 8'h00;
    baud_div = 16'h0050;
    rst = 1'b1;
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    t_reset;
    t_tx;
    t_tx_idle;
    t_rx_format;
    t_filter;
    t_rx_off;
    t_rx_err;
    t_overrun;
    close_out;
  end
endmodule
